// ---- hw/opd_discipline.sv ----
`timescale 1ns/100ps
`include "opd_map.svh"
module opd_discipline
#(
  parameter int P_TAG_PERIOD = `OPD_TAG_PERIOD_CYC,
  parameter int P_LOSS_CYC   = `OPD_LOSS_CYC,
  parameter int P_MIN_CYCLE  = `OPD_MIN_CYCLE_S,
  parameter int P_MAX_CYCLE  = `OPD_MAX_CYCLE_S
)
(
  input  wire logic         i_mclk,                 // 100 MHz clock
  input  wire logic         i_nrst,                 // Async reset, low
  input  wire logic         i_ext_second_tag_in,    // External tag pin
  input  wire logic         i_warm_done,            // Warm-up finished
  input  wire logic         i_lamp_lit,             // Lamp discharge on
  input  wire logic         i_lock_ok,              // Resonance locked
  input  wire logic         i_realign_req,          // Host realign pulse
  input  wire logic         i_freq_wr,              // Host freq write
  input  wire opd_pkg::opd_freq_t  i_freq_val,      // Host freq value
  input  wire logic         i_hist_rd,              // History read
  input  wire logic [7:0]   i_hist_idx,             // 0 = newest
  input  wire logic         i_telem_req,            // Telemetry request
  input  wire opd_pkg::opd_tsel_t  i_telem_sel,     // Telemetry select
  input  wire opd_pkg::opd_telem_t i_photo,         // Photocurrent
  input  wire opd_pkg::opd_telem_t i_ctrl_v,        // Osc control volt
  input  wire opd_pkg::opd_telem_t i_err_v,         // Error volt
  input  wire opd_pkg::opd_freq_t  i_nv_word,       // Saved freq value
  output logic              o_local_second_tag_out, // Local tag pin
  output opd_pkg::opd_freq_t o_freq_word,           // Freq register
  output logic              o_nv_save,              // Save strobe
  output opd_pkg::opd_freq_t o_nv_word,             // Value to save
  output opd_pkg::opd_freq_t o_hist_data,           // History reply
  output logic              o_hist_ack,             // History reply strobe
  output opd_pkg::opd_telem_t o_telem_data,         // Telemetry reply
  output logic              o_telem_ack,            // Telemetry strobe
  output logic              o_freq_ack,             // Freq write reply
  output logic              o_align_ack,            // Realign done
  output logic              o_lamp_off,             // Lamp not lit
  output logic              o_lock_fail,            // Not ready
  output logic              o_tying,                // Disciplining
  output logic              o_ext_present           // External tags seen
);
  import opd_pkg::*;

  localparam int CW = $clog2(P_TAG_PERIOD);
  localparam int LW = $clog2(P_LOSS_CYC + 1);
  localparam int SW = $clog2(P_MAX_CYCLE + 1);
  localparam int DW = `OPD_DIV_STEPS;
  localparam int HD = `OPD_HIST_DEPTH;
  localparam logic signed [DW-1:0] PER  = DW'(P_TAG_PERIOD);
  localparam logic signed [DW-1:0] HALF = DW'(P_TAG_PERIOD / 2);
  localparam logic [DW-1:0] HOLD   = DW'(`OPD_HOLD_ERR_CYC);
  localparam logic [DW-1:0] JIT_HI = DW'(`OPD_JIT_HI);
  localparam logic [DW-1:0] JIT_LO = DW'(`OPD_JIT_LO);
  localparam logic [DW-1:0] SCALE  = DW'(`OPD_UNIT_SCALE);
  localparam logic [LW-1:0] LOSS   = LW'(P_LOSS_CYC);
  localparam logic [SW-1:0] CMIN   = SW'(P_MIN_CYCLE);
  localparam logic [SW-1:0] CMAX   = SW'(P_MAX_CYCLE);
  localparam logic [8:0]    DEPTH  = 9'(HD);
  localparam logic [5:0]    STEPS  = 6'(DW);

  function automatic opd_freq_t sat_freq(input logic signed [DW-1:0] v);
    if (v > DW'(`OPD_FREQ_MAX))
      sat_freq = 16'(`OPD_FREQ_MAX);
    else if (v < -DW'(`OPD_FREQ_MAX))
      sat_freq = -16'(`OPD_FREQ_MAX);
    else
      sat_freq = v[15:0];
  endfunction : sat_freq

  function automatic logic [DW-1:0] mag(input logic signed [DW-1:0] v);
    mag = v[DW-1] ? -v : v;
  endfunction : mag

  // Pins cross in through three flops; a level counts once 2nd and 3rd agree
  logic [3:0] pin_raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] flt_q;
  logic [3:0] flt_d;
  assign pin_raw = {i_warm_done, i_lock_ok, i_lamp_lit, i_ext_second_tag_in};
  assign flt_d   = (s2_q & s3_q) | (flt_q & (s2_q | s3_q));

  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      s1_q  <= 4'h0;
      s2_q  <= 4'h0;
      s3_q  <= 4'h0;
      flt_q <= 4'h0;
    end
    else
    begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end

  logic ext_prev_q;
  logic ext_edge;
  logic warm;
  assign ext_edge = flt_q[0] & ~ext_prev_q;
  assign warm     = flt_q[3];

  // Local tag generator
  opd_tag_if #(.CW(CW)) tg ();
  opd_tag_gen #(
    .P_PERIOD (P_TAG_PERIOD),
    .P_WIDTH  (`OPD_TAG_WIDTH_CYC),
    .CW       (CW)
  ) u_tag (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .tg     (tg.gen),
    .o_tag  (o_local_second_tag_out)
  );

  logic signed [DW-1:0] off_raw;
  logic signed [DW-1:0] off_w;
  assign off_raw = $signed(DW'(tg.cnt)) - DW'(`OPD_EDGE_LAT);
  assign off_w   = (off_raw >= HALF) ? off_raw - PER : off_raw;

  // Loss watchdog: no edge for the loss time means no external tags
  logic [LW-1:0] loss_q;
  logic          present;
  assign present = (loss_q < LOSS);

  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      loss_q     <= LOSS;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_prev_q <= flt_q[0];
      if (ext_edge)
        loss_q <= '0;
      else if (present)
        loss_q <= loss_q + 1'b1;
    end

  logic pend_q;
  logic realign;
  assign realign = ext_edge & (pend_q | i_realign_req | (mag(off_w) > HOLD));
  // Preload so the next local tag lands on the external one
  assign tg.load     = realign;
  assign tg.load_val = CW'(`OPD_EDGE_LAT + 1);

  // Host request held until an external edge arrives; request wins over done
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      pend_q      <= 1'b0;
      o_align_ack <= 1'b0;
    end
    else
    begin
      pend_q      <= i_realign_req | (pend_q & ~realign);
      o_align_ack <= realign & (pend_q | i_realign_req);
    end

  // Disciplining state
  opd_state_t st_q;
  logic              first_q;
  logic [SW-1:0]     secs_q;
  logic [SW-1:0]     clen_q;
  logic signed [DW-1:0] start_q;
  logic signed [DW-1:0] prev_q;
  logic [DW-1:0]     jmax_q;
  logic [DW-1:0]     num_q;
  logic [16:0]       rem_q;
  logic [5:0]        step_q;
  logic              neg_q;

  logic signed [DW-1:0] drift;
  logic [DW-1:0]     jit_now;
  logic [16:0]       rem_sh;
  logic              rem_ge;
  logic              accurate;
  logic [SW-1:0]     clen_up;
  logic [SW-1:0]     clen_dn;
  assign drift    = prev_q - start_q;
  assign jit_now  = mag(off_w - prev_q);
  assign rem_sh   = {rem_q[15:0], num_q[DW-1]};
  assign rem_ge   = (rem_sh >= {1'b0, clen_q});
  assign accurate = (jmax_q <= JIT_HI);
  assign clen_up  = (clen_q >= (CMAX >> 1)) ? CMAX : SW'(clen_q << 1);
  assign clen_dn  = ((clen_q >> 1) <= CMIN) ? CMIN : (clen_q >> 1);

  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      st_q    <= OPD_WAIT;
      first_q <= 1'b1;
      secs_q  <= '0;
      clen_q  <= CMIN;
      start_q <= '0;
      prev_q  <= '0;
      jmax_q  <= '0;
      num_q   <= '0;
      rem_q   <= '0;
      step_q  <= '0;
      neg_q   <= 1'b0;
    end
    else
      unique case (st_q)
        OPD_WAIT:
          if (warm && present)
          begin
            st_q    <= OPD_TYING;
            first_q <= 1'b1;
          end
        OPD_TYING:
          if (!present || !warm)
          begin
            // Dropout: the source looks unstable, so stretch the cycle
            st_q   <= OPD_WAIT;
            clen_q <= clen_up;
          end
          else if (ext_edge && (first_q || realign))
          begin
            // A realign breaks phase continuity, so start afresh
            first_q <= 1'b0;
            secs_q  <= '0;
            jmax_q  <= '0;
            start_q <= realign ? '0 : off_w;
            prev_q  <= realign ? '0 : off_w;
          end
          else if (ext_edge)
          begin
            secs_q <= secs_q + 1'b1;
            prev_q <= off_w;
            if (jit_now > jmax_q)
              jmax_q <= jit_now;
            if (secs_q + 1'b1 >= clen_q)
            begin
              // numerator loaded before the first shift
              st_q  <= OPD_DIV;
              num_q <= DW'(mag(off_w - start_q) * SCALE);
            end
          end
        OPD_DIV:
        begin
          // restoring divide of scaled drift by cycle length
          rem_q  <= rem_ge ? rem_sh - {1'b0, clen_q} : rem_sh;
          num_q  <= {num_q[DW-2:0], rem_ge};
          step_q <= step_q + 1'b1;
          neg_q  <= drift[DW-1];
          if (step_q == STEPS - 1'b1)
            st_q <= OPD_APPLY;
        end
        OPD_APPLY:
        begin
          st_q    <= OPD_TYING;
          secs_q  <= '0;
          jmax_q  <= '0;
          start_q <= prev_q;
          rem_q   <= '0;
          step_q  <= '0;
          num_q   <= '0;
          if (!accurate)
            clen_q <= clen_up;
          else if (jmax_q <= JIT_LO)
            clen_q <= clen_dn;
        end
      endcase

  // Divider needs the numerator loaded before the first shift
  logic [DW-1:0] quot;
  logic signed [DW-1:0] corr;
  assign quot = num_q;
  assign corr = neg_q ? $signed(quot) : -$signed(quot);

  // Frequency register write sources
  opd_freq_t freq_q;
  logic      nv_done_q;
  logic      apply_ok;
  opd_freq_t corr_sat;
  opd_freq_t freq_auto;
  assign apply_ok  = (st_q == OPD_APPLY) && accurate;
  assign corr_sat  = sat_freq(corr);
  assign freq_auto = sat_freq(DW'(freq_q) + corr);

  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      freq_q     <= `OPD_FREQ_RST;
      nv_done_q  <= 1'b0;
      o_nv_save  <= 1'b0;
      o_freq_ack <= 1'b0;
    end
    else
    begin
      nv_done_q  <= 1'b1;
      o_freq_ack <= i_freq_wr & nv_done_q;
      o_nv_save  <= nv_done_q & (i_freq_wr | apply_ok);
      if (!nv_done_q)
        freq_q <= sat_freq(DW'(i_nv_word));
      else if (i_freq_wr)
        freq_q <= sat_freq(DW'(i_freq_val));
      else if (apply_ok)
        freq_q <= freq_auto;
    end

  assign o_freq_word = freq_q;
  assign o_nv_word   = freq_q;

  opd_freq_t     hist_mem [0:HD-1];
  logic [7:0]    wr_ptr_q;
  logic [8:0]    hcnt_q;
  logic [8:0]    rd_sum;
  logic [8:0]    rd_addr;
  assign rd_sum  = {1'b0, wr_ptr_q} + DEPTH - 9'h001 - {1'b0, i_hist_idx};
  assign rd_addr = (rd_sum >= DEPTH) ? rd_sum - DEPTH : rd_sum;

  always_ff @(posedge i_mclk)
    if (apply_ok)
      hist_mem[wr_ptr_q] <= corr_sat;

  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      wr_ptr_q    <= 8'h00;
      hcnt_q      <= 9'h000;
      o_hist_data <= 16'h0000;
      o_hist_ack  <= 1'b0;
    end
    else
    begin
      o_hist_ack <= i_hist_rd;
      if (apply_ok)
      begin
        wr_ptr_q <= (wr_ptr_q == 8'(HD - 1)) ? 8'h00 : wr_ptr_q + 1'b1;
        hcnt_q   <= (hcnt_q == DEPTH) ? DEPTH : hcnt_q + 1'b1;
      end
      if (i_hist_rd)
        o_hist_data <= ({1'b0, i_hist_idx} < hcnt_q) ?
                       hist_mem[rd_addr[7:0]] : 16'h0000;
    end

  opd_telem_t telem_sel;
  always_comb
  begin
    unique case (i_telem_sel)
      OPD_TEL_PHOTO: telem_sel = i_photo;
      OPD_TEL_CTRL:  telem_sel = i_ctrl_v;
      OPD_TEL_ERR:   telem_sel = i_err_v;
      default:       telem_sel = 12'h000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      o_telem_data <= 12'h000;
      o_telem_ack  <= 1'b0;
    end
    else
    begin
      o_telem_ack <= i_telem_req;
      if (i_telem_req)
        o_telem_data <= telem_sel;
    end

  // status pins; both show not-ready from reset on
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      o_lamp_off    <= 1'b1;
      o_lock_fail   <= 1'b1;
      o_tying       <= 1'b0;
      o_ext_present <= 1'b0;
    end
    else
    begin
      o_lamp_off    <= ~flt_q[1];
      o_lock_fail   <= ~flt_q[2];
      o_tying       <= (st_q != OPD_WAIT);
      o_ext_present <= present;
    end
endmodule : opd_discipline

// ---- hw/opd_map.svh ----
// Summary of operation
// - Local tag train repeats every second
// - Align local tags to external within 100ns
// - Keep tag offset within one microsecond
// - Host command forces realignment to external tags
// - Signed four digit frequency offset register
// - Register unit equals one part in 1e12
// - Host loads signed value into frequency register
// - Disciplining starts after warm-up with tags
// - Measure offset between local and external tags
// - Good measurement cycle updates frequency register
// - Stability estimate stretches or shrinks correction interval
// - First correction no sooner than forty minutes
// - Keep last 250 corrections, readable, volatile
// - Frequency register saved, reloaded at power-up
// - Lamp output shows unlit until discharge
// - Lock failure output shows not-ready until lock
// - Every host request gets a reply; a frequency write on the first edge after reset gets none
// - Telemetry values returned on matching request
`ifndef OPD_MAP_SVH
`define OPD_MAP_SVH
`define OPD_CLK_HZ        100000000
`define OPD_CLK_NS        10
`define OPD_TAG_PERIOD_S  1
`define OPD_TAG_PERIOD_CYC (`OPD_CLK_HZ * `OPD_TAG_PERIOD_S)
`define OPD_TAG_WIDTH_NS  10000
`define OPD_TAG_WIDTH_CYC (`OPD_TAG_WIDTH_NS / `OPD_CLK_NS)
`define OPD_ALIGN_ERR_NS  100
`define OPD_ALIGN_ERR_CYC (`OPD_ALIGN_ERR_NS / `OPD_CLK_NS)
`define OPD_HOLD_ERR_NS   1000
`define OPD_HOLD_ERR_CYC  (`OPD_HOLD_ERR_NS / `OPD_CLK_NS)
`define OPD_EDGE_LAT      4
`define OPD_LOSS_S        2
`define OPD_LOSS_CYC      (`OPD_CLK_HZ * `OPD_LOSS_S)
`define OPD_FIRST_CORR_MIN 40
`define OPD_MIN_CYCLE_S   (`OPD_FIRST_CORR_MIN * 60)
`define OPD_MAX_CYCLE_S   (`OPD_MIN_CYCLE_S * 8)
`define OPD_FREQ_MAX      9999
`define OPD_FREQ_RST      16'h0000
`define OPD_UNIT_SCALE    (`OPD_CLK_NS * 1000)
`define OPD_JIT_HI        20
`define OPD_JIT_LO        5
`define OPD_HIST_DEPTH    250
`define OPD_DIV_STEPS     48
`endif

// ---- hw/opd_pkg.sv ----
package opd_pkg;
  typedef logic signed [15:0] opd_freq_t;
  typedef logic [11:0]        opd_telem_t;
  typedef enum logic [1:0] {OPD_TEL_PHOTO, OPD_TEL_CTRL, OPD_TEL_ERR}
    opd_tsel_t;
  typedef enum logic [1:0] {OPD_WAIT, OPD_TYING, OPD_DIV, OPD_APPLY}
    opd_state_t;
endpackage : opd_pkg

// ---- hw/opd_tag_gen.sv ----
`timescale 1ns/100ps
module opd_tag_gen
#(
  parameter int P_PERIOD = 100000000,
  parameter int P_WIDTH  = 1000,
  parameter int CW       = 27
)
(
  input  wire logic i_mclk,  // System clock
  input  wire logic i_nrst,  // Async reset, active low
  opd_tag_if.gen    tg,      // Phase counter port
  output logic      o_tag    // Local second tag pulse
);
  localparam logic [CW-1:0] LAST  = CW'(P_PERIOD - 1);
  localparam logic [CW-1:0] WIDTH = CW'(P_WIDTH);

  assign tg.tick = (tg.cnt == LAST);

  // Phase counter; a load realigns the whole train at once
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
      tg.cnt <= '0;
    else if (tg.load)
      tg.cnt <= tg.load_val;
    else if (tg.tick)
      tg.cnt <= '0;
    else
      tg.cnt <= tg.cnt + 1'b1;

  // Pulse is a flop so the pin carries no decode glitches
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
      o_tag <= 1'b0;
    else
      o_tag <= (tg.cnt < WIDTH);
endmodule : opd_tag_gen

// ---- hw/opd_tag_if.sv ----
`timescale 1ns/100ps
interface opd_tag_if #(parameter int CW = 27);
  logic          load;
  logic [CW-1:0] load_val;
  logic [CW-1:0] cnt;
  logic          tick;
  modport gen (input load, load_val, output cnt, tick);
  modport ctl (output load, load_val, input cnt, tick);
endinterface : opd_tag_if

// ---- verification/opd_disc_assertions.sv ----
`timescale 1ns/100ps
module opd_disc_chk
(
  input wire logic               i_mclk,                 // Clock
  input wire logic               i_nrst,                 // Reset
  input wire logic               i_ext_second_tag_in,    // Ext tag
  input wire logic               i_warm_done,            // Warm
  input wire logic               i_lamp_lit,             // Lamp
  input wire logic               i_lock_ok,              // Lock
  input wire logic               i_freq_wr,              // Write
  input wire opd_pkg::opd_freq_t i_freq_val,             // Value
  input wire logic               o_local_second_tag_out, // Tag
  input wire opd_pkg::opd_freq_t o_freq_word,            // Register
  input wire logic               o_nv_save,              // Save
  input wire opd_pkg::opd_freq_t o_nv_word,              // Saved
  input wire logic               o_freq_ack,             // Ack
  input wire logic               o_lamp_off,             // Unlit
  input wire logic               o_lock_fail,            // Not ready
  input wire logic               o_tying                 // Tying
);
  import opd_pkg::*;
  logic        rdy_q;  // Requests count from 2nd edge
  logic        seen_q; // External tags seen
  logic [10:0] hi_q;   // High cycles of local tag

  // Width is only exact before external tags may reload the train
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      rdy_q  <= 1'b0;
      seen_q <= 1'b0;
      hi_q   <= 11'h000;
    end
    else
    begin
      rdy_q  <= 1'b1;
      seen_q <= seen_q | i_ext_second_tag_in;
      hi_q   <= o_local_second_tag_out ? hi_q + 11'h001 : 11'h000;
    end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  freq_ack_a : assert property (
    rdy_q && i_freq_wr |=> o_freq_ack) else $error("no write ack");
  freq_load_a : assert property (
    rdy_q && i_freq_wr && i_freq_val >= -9999 && i_freq_val <= 9999
    |=> o_freq_word == $past(i_freq_val)) else $error("bad load");
  freq_sat_a : assert property (
    rdy_q && i_freq_wr && i_freq_val < -9999
    |=> o_freq_word == 16'shD8F1) else $error("no saturation");
  freq_range_a : assert property (
    o_freq_word >= -9999 && o_freq_word <= 9999) else $error("range");
  nv_mirror_a : assert property (
    o_nv_word == o_freq_word) else $error("saved word differs");
  nv_save_a : assert property (
    o_freq_ack && o_freq_word != $past(o_freq_word) |-> o_nv_save)
    else $error("no save strobe");
  lamp_follow_a : assert property (
    $stable(i_lamp_lit)[*8] |-> o_lamp_off == !i_lamp_lit)
    else $error("lamp status");
  lock_follow_a : assert property (
    $stable(i_lock_ok)[*8] |-> o_lock_fail == !i_lock_ok)
    else $error("lock status");
  tying_idle_a : assert property (
    !i_warm_done[*8] |-> !o_tying) else $error("tying before warm");
  tag_width_a : assert property (
    !seen_q && $fell(o_local_second_tag_out) |-> hi_q == 11'h3E8)
    else $error("tag width");
endmodule : opd_disc_chk

bind opd_discipline opd_disc_chk u_chk (
  .i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_ext_second_tag_in(i_ext_second_tag_in), .i_warm_done(i_warm_done),
  .i_lamp_lit(i_lamp_lit), .i_lock_ok(i_lock_ok), .i_freq_wr(i_freq_wr),
  .i_freq_val(i_freq_val), .o_local_second_tag_out(o_local_second_tag_out),
  .o_freq_word(o_freq_word), .o_nv_save(o_nv_save),
  .o_nv_word(o_nv_word), .o_freq_ack(o_freq_ack),
  .o_lamp_off(o_lamp_off), .o_lock_fail(o_lock_fail), .o_tying(o_tying));

// ---- verification/opd_sec_src.sv ----
`timescale 1ns/100ps
module opd_sec_src
(
  input  wire logic        i_mclk, // Clock
  input  wire logic        i_en,   // Source running
  input  wire logic [15:0] i_per,  // Period in cycles
  output logic             o_tag   // External tag pin
);
  logic [15:0] cnt_q;   // Cycle within second
  logic        pulse_q; // Pulse phase

  // 100-cycle pulse each period; a stopped source drives its idle low
  always_ff @(posedge i_mclk)
    if (!i_en)
    begin
      cnt_q   <= 16'h0000;
      pulse_q <= 1'b0;
    end
    else
    begin
      cnt_q   <= (cnt_q == i_per - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
      pulse_q <= cnt_q < 16'h0064;
    end

  // Gated so the pin is low from time zero
  assign o_tag = i_en & pulse_q;
endmodule : opd_sec_src

// ---- verification/tb.sv ----
`timescale 1ns/100ps
module tb;
  import opd_pkg::*;
  localparam int         PER = 2000;   // Shortened second
  localparam opd_telem_t PHO = 12'h0A5; // Photocurrent level
  localparam opd_telem_t CTL = 12'h5A3; // Control voltage
  localparam opd_telem_t ERV = 12'hF0F; // Error voltage
  logic       i_mclk = 1'b0, i_nrst = 1'b0, i_warm_done = 1'b0;
  logic       i_lamp_lit = 1'b0, i_lock_ok = 1'b0, i_realign_req = 1'b0;
  logic       i_freq_wr = 1'b0, i_hist_rd = 1'b0, i_telem_req = 1'b0;
  logic       ext_en = 1'b0, ext_tag;
  logic [7:0] i_hist_idx = 8'h00;
  opd_freq_t  i_freq_val = 16'h0000;
  opd_tsel_t  i_telem_sel = OPD_TEL_PHOTO;
  logic       o_tag, o_nv_save, o_hist_ack, o_telem_ack, o_freq_ack;
  logic       o_align_ack, o_lamp_off, o_lock_fail, o_tying, o_ext_present;
  opd_freq_t  o_freq_word, o_nv_word, o_hist_data, f0, hd;
  opd_telem_t o_telem_data;
  time        t0, t_ext, t_loc, d;
  int         n, n_fail = 0, checks = 0;
  opd_freq_t  wv [5] = '{16'h0064, 16'hD8F1, 16'h2EE0, 16'hD120, 16'h0000};
  opd_freq_t  we [5] = '{16'h0064, 16'hD8F1, 16'h270F, 16'hD8F1, 16'h0000};
  opd_telem_t tv [4] = '{PHO, CTL, ERV, 12'h000};

  // Clock and edge time stamps
  always #5 i_mclk = ~i_mclk;
  always @(posedge ext_tag) t_ext = $time;
  always @(posedge o_tag) t_loc = $time;

  opd_discipline #(.P_TAG_PERIOD(PER), .P_LOSS_CYC(5000),
    .P_MIN_CYCLE(4), .P_MAX_CYCLE(32)) DUT (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_ext_second_tag_in(ext_tag),
    .i_warm_done(i_warm_done), .i_lamp_lit(i_lamp_lit),
    .i_lock_ok(i_lock_ok), .i_realign_req(i_realign_req),
    .i_freq_wr(i_freq_wr), .i_freq_val(i_freq_val), .i_hist_rd(i_hist_rd),
    .i_hist_idx(i_hist_idx), .i_telem_req(i_telem_req),
    .i_telem_sel(i_telem_sel), .i_photo(PHO), .i_ctrl_v(CTL),
    .i_err_v(ERV), .i_nv_word(16'h04D2), .o_local_second_tag_out(o_tag),
    .o_freq_word(o_freq_word), .o_nv_save(o_nv_save),
    .o_nv_word(o_nv_word), .o_hist_data(o_hist_data),
    .o_hist_ack(o_hist_ack), .o_telem_data(o_telem_data),
    .o_telem_ack(o_telem_ack), .o_freq_ack(o_freq_ack),
    .o_align_ack(o_align_ack), .o_lamp_off(o_lamp_off),
    .o_lock_fail(o_lock_fail), .o_tying(o_tying),
    .o_ext_present(o_ext_present));

  opd_sec_src u_src (.i_mclk(i_mclk), .i_en(ext_en), .i_per(16'h07D3),
    .o_tag(ext_tag));

  // Compare and count; an unknown never matches
  task chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // Host write; answer registered on the taking edge itself, checked 1 ns later
  task wr_freq(input opd_freq_t v, e);
    @(posedge i_mclk);
    i_freq_wr  <= 1'b1;
    i_freq_val <= v;
    @(posedge i_mclk);
    i_freq_wr <= 1'b0;
    #1;
    chk(16'(o_freq_ack), 16'h0001, "write ack");
    chk(o_freq_word, e, "word");
    chk(16'(o_nv_save), 16'h0001, "save");
    chk(o_nv_word, e, "saved word");
  endtask : wr_freq

  task rd_hist(input logic [7:0] idx);
    @(posedge i_mclk);
    i_hist_rd  <= 1'b1;
    i_hist_idx <= idx;
    @(posedge i_mclk);
    i_hist_rd <= 1'b0;
    #1;
    chk(16'(o_hist_ack), 16'h0001, "hist ack");
    hd = o_hist_data;
  endtask : rd_hist

  task rd_tel(input opd_tsel_t s, input opd_telem_t e);
    @(posedge i_mclk);
    i_telem_req <= 1'b1;
    i_telem_sel <= s;
    @(posedge i_mclk);
    i_telem_req <= 1'b0;
    #1;
    chk(16'(o_telem_ack), 16'h0001, "tel ack");
    chk(16'(o_telem_data), 16'(e), "tel data");
  endtask : rd_tel

  // Watchdog sized above the longest correction wait
  initial
  begin
    #(PER * 45 * 10);
    n_fail++;
    $display("mismatch %0t watchdog expired", $time);
    final_report();
  end

  // Test sequence
  initial
  begin
    repeat (19) @(posedge i_mclk);
    #1;
    chk(16'(o_lamp_off), 16'h0001, "lamp in reset");
    chk(16'(o_lock_fail), 16'h0001, "lock in reset");
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
    chk(o_freq_word, 16'h04D2, "restored");
    chk(16'(o_nv_save), 16'h0000, "save at start");
    $display("test reset done");
    @(posedge o_tag);
    t0 = $time;
    @(posedge o_tag);
    chk(16'($time - t0), 16'(PER * 10), "tag period");
    $display("test tag done");
    for (int k = 0; k < 5; k++)
      wr_freq(wv[k], we[k]);
    for (int k = 0; k < 4; k++)
      rd_tel(opd_tsel_t'(k), tv[k]);
    rd_hist(8'h00);
    chk(hd, 16'h0000, "empty history");
    $display("test host done");
    @(posedge i_mclk);
    i_lamp_lit <= 1'b1;
    i_lock_ok  <= 1'b1;
    repeat (10) @(posedge i_mclk);
    #1;
    chk(16'(o_lamp_off), 16'h0000, "lamp lit");
    chk(16'(o_lock_fail), 16'h0000, "locked");
    $display("test status done");
    @(posedge i_mclk);
    ext_en <= 1'b1;
    repeat (3 * PER + 100) @(posedge i_mclk);
    #1;
    chk(16'(o_tying), 16'h0000, "tying early");
    chk(16'(o_ext_present), 16'h0001, "ext seen");
    @(posedge i_mclk);
    i_warm_done <= 1'b1;
    repeat (20) @(posedge i_mclk);
    #1;
    chk(16'(o_tying), 16'h0001, "tying");
    t0 = $time;
    @(posedge i_mclk);
    i_realign_req <= 1'b1;
    @(posedge i_mclk);
    i_realign_req <= 1'b0;
    n = 0;
    while (o_align_ack !== 1'b1 && n < 3 * PER)
    begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    d = ($time - t_ext) / 10;
    chk(16'(d >= 4 && d <= 7), 16'h0001, "realign ack");
    @(posedge o_tag);
    repeat (200) @(posedge i_mclk);
    d = (t_loc > t_ext) ? t_loc - t_ext : t_ext - t_loc;
    chk(16'(d <= 100), 16'h0001, "aligned");
    f0 = o_freq_word;
    n = 0;
    while (o_freq_word === f0 && n < 30 * PER)
    begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk(16'(o_freq_word !== f0), 16'h0001, "correction");
    chk(o_freq_word, 16'hD8F1, "corr value");
    chk(16'(o_nv_save), 16'h0001, "auto save");
    d = (t_loc > t_ext) ? t_loc - t_ext : t_ext - t_loc;
    chk(16'(d <= 1000), 16'h0001, "held");
    chk(16'($time - t0 >= 4 * PER * 10), 16'h0001, "early");
    rd_hist(8'h00);
    chk(hd, 16'hD8F1, "newest entry");
    rd_hist(8'h01);
    chk(hd, 16'h0000, "beyond count");
    $display("test discipline done");
    final_report();
  end
endmodule : tb
